/* File: hw/dcc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dcc_defs.svh"

module dcc_top #(
  parameter int                  AW          = 8,
  parameter dcc_pkg::dcc_table_t MODE_TABLE  = {8{dcc_pkg::DCC_ROW_DEFAULT}}
) (
  input  wire logic          SYS_CLK,
  input  wire logic          RESET,
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic [31:0]   HWDATA,
  input  wire logic          HREADY,
  output logic      [31:0]   HRDATA,
  output logic               HREADYOUT,
  output logic               HRESP,
  input  wire logic [AW-1:0] ANALOG_IN0,
  input  wire logic [AW-1:0] ANALOG_IN1,
  input  wire logic [AW-1:0] ANALOG_IN2,
  input  wire logic [AW-1:0] ANALOG_IN3,
  input  wire logic [AW-1:0] VREF_LEVEL,
  input  wire logic [5:0]    PORT_IN,
  output logic      [5:0]    PORT_OUT,
  output logic      [5:0]    PORT_OE,
  input  wire logic          SLEEP,
  output logic               IRQ,
  output logic               WAKE
);
  import dcc_pkg::*;

  // --------------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------------
  if (AW < 2 || AW > 16) begin : g_bad_aw
    $error("AW must lie between 2 and 16");
  end

  dcc_cmp_if cmp ();  // link to the change detector

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [5:0]  ctrl_q;      // invert, switch, mode
  logic        flag_q;      // comparator interrupt flag
  logic        irq_en_q;    // comparator interrupt enable
  logic        global_en_q; // global enable
  logic        periph_en_q; // peripheral enable
  logic [5:0]  dir_q;       // port direction, 1 = input
  logic [3:0]  pcfg_q;      // port analog configuration
  logic [5:0]  lat_q;       // port output latch
  logic [31:0] hrdata_q;    // read data for the data phase
  logic        wr_q;        // write data phase pending
  logic [7:0]  waddr_q;     // address of that write
  logic [5:0]  pin_a_q;     // pin synchronizer stage 1
  logic [5:0]  pin_b_q;     // stage 2
  logic [5:0]  pin_c_q;     // stage 3
  logic [5:0]  pin_q;       // accepted pin levels

  wire  [2:0]  mode   = ctrl_q[2:0];
  wire         in_sw  = ctrl_q[`DCC_BIT_IN_SWITCH];
  wire  [1:0]  inv    = ctrl_q[`DCC_BIT_CMP2_INV:`DCC_BIT_CMP1_INV];

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  logic       addr_ok;  // address phase accepted
  logic [7:0] aofs;     // byte offset of the address phase
  logic       rd_ctrl;  // control read in this address phase
  logic       wr_ctrl;  // control write in this data phase
  logic       wr_flag;  // flag register write in this data phase

  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign aofs    = HADDR[7:0];
  assign rd_ctrl = addr_ok && !HWRITE && (aofs == `DCC_OFS_CTRL);
  assign wr_ctrl = wr_q && (waddr_q == `DCC_OFS_CTRL);
  assign wr_flag = wr_q && (waddr_q == `DCC_OFS_IRQ_REQ2);

  // zero-wait slave, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_q;

  // capture write address for the following data phase
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      wr_q    <= 1'b0;
      waddr_q <= 8'h00;
    end else if (HREADY) begin
      wr_q    <= addr_ok && HWRITE;
      waddr_q <= aofs;
    end
  end

  // --------------------------------------------------------------------
  // mode routing and comparators
  // --------------------------------------------------------------------
  dcc_route_t row;       // active routing
  logic [1:0] gt;        // positive above negative
  logic [1:0] res;       // post-inversion results

  function automatic logic [AW-1:0] pick(input dcc_src_t s, input logic vref_ok);
    case (s)
      DCC_SRC_IN0:  pick = ANALOG_IN0;
      DCC_SRC_IN1:  pick = ANALOG_IN1;
      DCC_SRC_IN2:  pick = ANALOG_IN2;
      DCC_SRC_IN3:  pick = ANALOG_IN3;
      DCC_SRC_VREF: pick = vref_ok ? VREF_LEVEL : '0;
      default:      pick = '0;
    endcase
  endfunction

  // select one of eight configurations
  always_comb begin
    row = MODE_TABLE[mode];
    if (mode == `DCC_MODE_MUX4) begin
      // reference on both positive inputs, switch picks negatives
      row.enable    = 2'h3;
      row.pin_route = 1'b0;
      row.c1_pos    = DCC_SRC_VREF;
      row.c2_pos    = DCC_SRC_VREF;
      row.c1_neg    = in_sw ? DCC_SRC_IN3 : DCC_SRC_IN0;
      row.c2_neg    = in_sw ? DCC_SRC_IN2 : DCC_SRC_IN1;
    end else if (mode == `DCC_MODE_OFF) begin
      // both comparators off
      row.enable    = 2'h0;
      row.pin_route = 1'b0;
    end
  end

  // compare and invert; runs regardless of SLEEP
  always_comb begin
    gt[0]  = pick(row.c1_pos, mode == `DCC_MODE_MUX4) > pick(row.c1_neg, 1'b0);
    gt[1]  = pick(row.c2_pos, mode == `DCC_MODE_MUX4) > pick(row.c2_neg, 1'b0);
    res    = row.enable & (gt ^ inv);
  end

  assign cmp.raw     = res;
  assign cmp.relatch = rd_ctrl || wr_ctrl;

  dcc_change_detect u_det (
    .SYS_CLK (SYS_CLK),
    .RESET   (RESET),
    .cmp     (cmp)
  );

  // --------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------
  // result bits are not stored, so writes to them vanish
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl_q <= `DCC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= HWDATA[5:0];
    end
  end

  // --------------------------------------------------------------------
  // interrupt flag and enables
  // --------------------------------------------------------------------
  // mismatch set wins over a software clear
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      flag_q <= 1'b0;
    end else if (cmp.mismatch) begin
      flag_q <= 1'b1;
    end else if (wr_flag) begin
      flag_q <= HWDATA[`DCC_BIT_IRQ_FLAG];
    end
  end

  // enable bits
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      irq_en_q    <= 1'b0;
      global_en_q <= 1'b0;
      periph_en_q <= 1'b0;
    end else if (wr_q) begin
      if (waddr_q == `DCC_OFS_IRQ_EN2) begin
        irq_en_q <= HWDATA[`DCC_BIT_IRQ_EN];
      end
      if (waddr_q == `DCC_OFS_IRQ_MAIN) begin
        global_en_q <= HWDATA[`DCC_BIT_GLOBAL_EN];
        periph_en_q <= HWDATA[`DCC_BIT_PERIPH_EN];
      end
    end
  end

  // request needs all three enables
  assign IRQ  = flag_q && irq_en_q && periph_en_q && global_en_q;
  // wake needs only the comparator enable, and only while asleep
  assign WAKE = SLEEP && flag_q && irq_en_q;

  // --------------------------------------------------------------------
  // port registers
  // --------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      dir_q  <= `DCC_DIR_RST;
      pcfg_q <= `DCC_PCFG_RST;
      lat_q  <= `DCC_LAT_RST;
    end else if (wr_q) begin
      if (waddr_q == `DCC_OFS_PORT_DIR) begin
        dir_q <= HWDATA[5:0];
      end
      if (waddr_q == `DCC_OFS_CONV_CTL1) begin
        pcfg_q <= HWDATA[3:0];
      end
      if (waddr_q == `DCC_OFS_PORT_LAT) begin
        lat_q <= HWDATA[5:0];
      end
    end
  end

  // analog pins 0..3 follow the config field, not the mode
  logic [3:0] analog_pin;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      analog_pin[i] = (pcfg_q < 4'(15 - i));
    end
  end

  // pin input synchronizer, change counts when stages two and three agree
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pin_a_q <= 6'h00;
      pin_b_q <= 6'h00;
      pin_c_q <= 6'h00;
      pin_q   <= 6'h00;
    end else begin
      pin_a_q <= PORT_IN;
      pin_b_q <= pin_a_q;
      pin_c_q <= pin_b_q;
      pin_q   <= (pin_b_q & ~(pin_b_q ^ pin_c_q)) | (pin_q & (pin_b_q ^ pin_c_q));
    end
  end

  // pins 4,5 from raw results, still gated by direction
  assign PORT_OUT = row.pin_route ? {res[1], res[0], lat_q[3:0]} : lat_q;
  assign PORT_OE  = ~dir_q;

  // --------------------------------------------------------------------
  // read data, captured in the address phase
  // --------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      hrdata_q <= 32'h00000000;
    end else if (addr_ok && !HWRITE) begin
      case (aofs)
        `DCC_OFS_CTRL:      hrdata_q <= {24'h000000, cmp.stable, ctrl_q};
        `DCC_OFS_IRQ_REQ2:  hrdata_q <= {24'h000000, 1'b0, flag_q, 6'h00};
        `DCC_OFS_IRQ_EN2:   hrdata_q <= {24'h000000, 1'b0, irq_en_q, 6'h00};
        `DCC_OFS_IRQ_MAIN:  hrdata_q <= {24'h000000, global_en_q, periph_en_q, 6'h00};
        `DCC_OFS_PORT_DIR:  hrdata_q <= {26'h0000000, dir_q};
        `DCC_OFS_PORT_DATA: hrdata_q <= {26'h0000000, pin_q[5:4],
                                         pin_q[3:0] & ~analog_pin};
        `DCC_OFS_CONV_CTL1: hrdata_q <= {28'h0000000, pcfg_q};
        `DCC_OFS_PORT_LAT:  hrdata_q <= {26'h0000000, lat_q};
        default:            hrdata_q <= 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence s_flag_write(bit v);
    wr_flag && (HWDATA[`DCC_BIT_IRQ_FLAG] == v) && !cmp.mismatch;
  endsequence

  sequence s_port_read;
    addr_ok && !HWRITE && (aofs == `DCC_OFS_PORT_DATA);
  endsequence

  a_mode_off: assert property (mode == `DCC_MODE_OFF |-> res == 2'h0)
    else $error("comparators active in off mode");
  a_reset_mode: assert property ($past(RESET) |-> mode == `DCC_MODE_OFF)
    else $error("mode not off after reset");
  a_mux4_route: assert property (mode == `DCC_MODE_MUX4 && !in_sw && !inv[0]
                                 |-> res[0] == (VREF_LEVEL > ANALOG_IN0))
    else $error("mode 110 routing wrong for comparator 1");
  a_irq_gate: assert property (IRQ |-> flag_q && irq_en_q && periph_en_q && global_en_q)
    else $error("request raised without all enables");
  a_flag_clear: assert property (s_flag_write(1'b0) |=> !flag_q || cmp.mismatch)
    else $error("flag not cleared by zero write");
  a_flag_soft_set: assert property (s_flag_write(1'b1) |=> flag_q)
    else $error("flag not set by one write");
  a_mismatch_set: assert property (cmp.mismatch |=> flag_q [*1])
    else $error("mismatch did not set flag");
  a_pin_route: assert property (row.pin_route && !dir_q[4] |->
                                PORT_OUT[4] == res[0] && PORT_OE[4])
    else $error("pin 4 not driven from comparator 1");
  a_analog_zero: assert property (s_port_read ##0 analog_pin[0] |=> HRDATA[0] == 1'b0)
    else $error("analog pin read as one");

endmodule

`default_nettype wire

/* File: hw/dcc_defs.svh */
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets (decoded on haddr[7:0])
// ----------------------------------------------------------------------
`define DCC_OFS_CTRL      8'h00
`define DCC_OFS_IRQ_REQ2  8'h04
`define DCC_OFS_IRQ_EN2   8'h08
`define DCC_OFS_IRQ_MAIN  8'h0C
`define DCC_OFS_PORT_DIR  8'h10
`define DCC_OFS_PORT_DATA 8'h14
`define DCC_OFS_CONV_CTL1 8'h18
`define DCC_OFS_PORT_LAT  8'h1C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DCC_BIT_CMP2_RES  7
`define DCC_BIT_CMP1_RES  6
`define DCC_BIT_CMP2_INV  5
`define DCC_BIT_CMP1_INV  4
`define DCC_BIT_IN_SWITCH 3
`define DCC_BIT_IRQ_FLAG  6
`define DCC_BIT_IRQ_EN    6
`define DCC_BIT_GLOBAL_EN 7
`define DCC_BIT_PERIPH_EN 6

// ----------------------------------------------------------------------
// mode codes and reset values
// ----------------------------------------------------------------------
`define DCC_MODE_MUX4     3'h6
`define DCC_MODE_OFF      3'h7
`define DCC_CTRL_RST      6'h07
`define DCC_DIR_RST       6'h3F
`define DCC_PCFG_RST      4'h0
`define DCC_LAT_RST       6'h00
`define DCC_HTRANS_NONSEQ 2'h2

`endif

/* File: hw/dcc_pkg.sv */
package dcc_pkg;

  // --------------------------------------------------------------------
  // input source selectors for one comparator input
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    DCC_SRC_IN0  = 3'h0,  // analog input 0
    DCC_SRC_IN1  = 3'h1,  // analog input 1
    DCC_SRC_IN2  = 3'h2,  // analog input 2
    DCC_SRC_IN3  = 3'h3,  // analog input 3
    DCC_SRC_VREF = 3'h4,  // internal reference
    DCC_SRC_ZERO = 3'h5   // tied low
  } dcc_src_t;

  // --------------------------------------------------------------------
  // one row of the mode table
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] enable;    // comparator 2, comparator 1 powered
    logic       pin_route; // outputs drive port pins 4 and 5
    dcc_src_t   c1_pos;
    dcc_src_t   c1_neg;
    dcc_src_t   c2_pos;
    dcc_src_t   c2_neg;
  } dcc_route_t;

  typedef dcc_route_t [7:0] dcc_table_t;

  // plain default row: two independent comparators, no pin routing
  localparam dcc_route_t DCC_ROW_DEFAULT = '{
    enable: 2'h3, pin_route: 1'b0,
    c1_pos: DCC_SRC_IN3, c1_neg: DCC_SRC_IN0,
    c2_pos: DCC_SRC_IN2, c2_neg: DCC_SRC_IN1};

endpackage

/* File: hw/dcc_cmp_if.sv */
`timescale 1ns/10ps
`default_nettype none

// carries comparator results between the register core and the detector
interface dcc_cmp_if;
  logic [1:0] raw;      // live comparator results, unsynchronized
  logic [1:0] stable;   // synchronized results
  logic [1:0] latched;  // copy taken at the last control access
  logic       relatch;  // one-cycle pulse: take a new copy
  logic       mismatch; // stable differs from latched

  modport core (output raw, output relatch, input stable, input latched, input mismatch);
  modport det  (input raw, input relatch, output stable, output latched, output mismatch);
endinterface

`default_nettype wire

/* File: hw/dcc_change_detect.sv */
`timescale 1ns/10ps
`default_nettype none

module dcc_change_detect (
  input  wire logic SYS_CLK,
  input  wire logic RESET,
  dcc_cmp_if.det    cmp
);
  import dcc_pkg::*;

  logic [1:0] s1_q;       // first synchronizer stage
  logic [1:0] s2_q;       // second stage
  logic [1:0] s3_q;       // third stage
  logic [1:0] stable_q;   // accepted value
  logic [1:0] latched_q;  // copy for mismatch

  // --------------------------------------------------------------------
  // synchronizer: a change counts once stages two and three agree
  // --------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
    end else begin
      s1_q <= cmp.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept per bit when the later stages agree
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      stable_q <= 2'h0;
    end else begin
      stable_q <= (s2_q & ~(s2_q ^ s3_q)) | (stable_q & (s2_q ^ s3_q));
    end
  end

  // copy taken on every control access
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      latched_q <= 2'h0;
    end else if (cmp.relatch) begin
      latched_q <= stable_q;
    end
  end

  assign cmp.stable   = stable_q;
  assign cmp.latched  = latched_q;
  assign cmp.mismatch = (stable_q != latched_q);

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  // only bits that moved need agreement; the other bit may still be settling
  a_sync_agree: assert property ($changed(stable_q) |->
                                 ((stable_q ^ $past(stable_q)) & ($past(s2_q) ^ $past(s3_q)))
                                 == 2'h0)
    else $error("stable value changed without stage agreement");
  a_relatch_copy: assert property (cmp.relatch |=> latched_q == $past(stable_q))
    else $error("relatch did not copy the stable value");
  a_hold_copy: assert property (!cmp.relatch |=> $stable(latched_q))
    else $error("latched copy changed without access");

endmodule

`default_nettype wire

/* File: dv/dcc_analog_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// analog pin and reference levels seen by the comparators
// ----------------------------------------------------------------------
module dcc_analog_model (
  output logic [7:0] ain0,
  output logic [7:0] ain1,
  output logic [7:0] ain2,
  output logic [7:0] ain3,
  output logic [7:0] vref
);
  // all levels start at ground
  initial begin
    ain0 = 8'h00;
    ain1 = 8'h00;
    ain2 = 8'h00;
    ain3 = 8'h00;
    vref = 8'h00;
  end

  // levels move off the clock edge, as a real pin would
  task automatic set_levels(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] a2,
                            input logic [7:0] a3, input logic [7:0] vr);
    #7;
    ain0 = a0;
    ain1 = a1;
    ain2 = a2;
    ain3 = a3;
    vref = vr;
  endtask
endmodule

`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dcc_defs.svh"

module testbench;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        sys_clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  ain0;
  logic [7:0]  ain1;
  logic [7:0]  ain2;
  logic [7:0]  ain3;
  logic [7:0]  vref;
  logic [5:0]  port_in;
  logic [5:0]  port_out;
  logic [5:0]  port_oe;
  logic        sleep;
  logic        irq;
  logic        wake;
  int          miscompares;
  int          tests_run;
  logic [31:0] rd;
  logic [31:0] exp_ctrl;

  // one row: mode setting, analog levels, expected results {cmp2,cmp1}
  typedef struct {
    logic [2:0] mode;
    logic [1:0] inv;
    logic       in_sw;
    logic [7:0] a0, a1, a2, a3, vr;
    logic [1:0] res;
  } dcc_tb_row_t;

  dcc_tb_row_t rows [9] = '{
    '{3'h0, 2'h0, 1'b0, 8'h28, 8'h14, 8'h0A, 8'h50, 8'h00, 2'h1},
    '{3'h1, 2'h0, 1'b0, 8'h28, 8'h14, 8'h0A, 8'h50, 8'h00, 2'h1},
    '{3'h2, 2'h3, 1'b0, 8'h28, 8'h14, 8'h0A, 8'h50, 8'h00, 2'h2},
    '{3'h3, 2'h1, 1'b0, 8'h28, 8'h14, 8'h0A, 8'h50, 8'h00, 2'h0},
    '{3'h4, 2'h2, 1'b0, 8'h28, 8'h14, 8'h0A, 8'h50, 8'h00, 2'h3},
    '{3'h5, 2'h0, 1'b0, 8'h28, 8'h14, 8'h1E, 8'h28, 8'h00, 2'h2},
    '{3'h6, 2'h0, 1'b0, 8'h28, 8'h3C, 8'h14, 8'h3C, 8'h32, 2'h1},
    '{3'h6, 2'h0, 1'b1, 8'h28, 8'h3C, 8'h14, 8'h3C, 8'h32, 2'h2},
    '{3'h7, 2'h3, 1'b0, 8'h28, 8'h14, 8'h0A, 8'h50, 8'h00, 2'h0}};

  // ----------------------------------------------------------------------
  // design, far side and clock
  // ----------------------------------------------------------------------
  // mode 5 keeps the default routing but also drives pins 4 and 5
  localparam dcc_pkg::dcc_route_t ROW_PINS = '{
    enable: 2'h3, pin_route: 1'b1,
    c1_pos: dcc_pkg::DCC_SRC_IN3, c1_neg: dcc_pkg::DCC_SRC_IN0,
    c2_pos: dcc_pkg::DCC_SRC_IN2, c2_neg: dcc_pkg::DCC_SRC_IN1};
  localparam dcc_pkg::dcc_table_t TB_TABLE = {{2{dcc_pkg::DCC_ROW_DEFAULT}}, ROW_PINS,
                                              {5{dcc_pkg::DCC_ROW_DEFAULT}}};

  dcc_top #(.MODE_TABLE(TB_TABLE)) dcc_top_inst (
    .SYS_CLK(sys_clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .ANALOG_IN0(ain0), .ANALOG_IN1(ain1),
    .ANALOG_IN2(ain2), .ANALOG_IN3(ain3), .VREF_LEVEL(vref), .PORT_IN(port_in),
    .PORT_OUT(port_out), .PORT_OE(port_oe), .SLEEP(sleep), .IRQ(irq), .WAKE(wake));

  dcc_analog_model dcc_analog_model_inst (
    .ain0(ain0), .ain1(ain1), .ain2(ain2), .ain3(ain3), .vref(vref));

  // 20 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  // verdict and end of run
  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare one value
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait for hready high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= `DCC_HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rdat = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000, rd);
    chk(what, rd, exp);
  endtask

  // register and pin state right after a reset
  task automatic check_reset_vals();
    rdchk("ctrl", `DCC_OFS_CTRL, 32'h00000007);
    rdchk("flag", `DCC_OFS_IRQ_REQ2, 32'h00000000);
    rdchk("dir", `DCC_OFS_PORT_DIR, 32'h0000003F);
    rdchk("pcfg", `DCC_OFS_CONV_CTL1, 32'h00000000);
    @(negedge sys_clk);
    chk("oe", {26'h0, port_oe}, 32'h00000000);
    chk("irq", {31'h0, irq}, 32'h00000000);
    chk("hresp", {31'h0, hresp}, 32'h00000000);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    miscompares = 0;
    tests_run = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    port_in = 6'h3F;
    sleep = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    check_reset_vals();
    // every mode code; interrupt enables stay clear while modes change
    foreach (rows[i]) begin
      dcc_analog_model_inst.set_levels(rows[i].a0, rows[i].a1, rows[i].a2, rows[i].a3,
                                       rows[i].vr);
      wr(`DCC_OFS_CTRL, {24'h0, 2'h3, rows[i].inv, rows[i].in_sw, rows[i].mode});
      repeat (6) @(posedge sys_clk);
      exp_ctrl = {24'h0, rows[i].res, rows[i].inv, rows[i].in_sw, rows[i].mode};
      rdchk("ctrl", `DCC_OFS_CTRL, exp_ctrl);
    end
    // analog pins read zero, the boundary of the config field
    rdchk("pdat", `DCC_OFS_PORT_DATA, 32'h00000030);
    wr(`DCC_OFS_CONV_CTL1, 32'h0000000D);
    rdchk("pdat", `DCC_OFS_PORT_DATA, 32'h0000003C);
    wr(`DCC_OFS_CONV_CTL1, 32'h0000000F);
    rdchk("pdat", `DCC_OFS_PORT_DATA, 32'h0000003F);
    // cleared direction bits enable pins 4,5; latch shows on low pins while they are inputs
    wr(`DCC_OFS_PORT_DIR, 32'h0000000F);
    wr(`DCC_OFS_PORT_LAT, 32'h0000002A);
    @(negedge sys_clk);
    chk("oe", {26'h0, port_oe}, 32'h00000030);
    chk("pout", {28'h0, port_out[3:0]}, 32'h0000000A);
    // mode 5 routes raw results to pins 4,5 before any clock could carry them
    wr(`DCC_OFS_CTRL, 32'h00000005);
    dcc_analog_model_inst.set_levels(8'h28, 8'h14, 8'h0A, 8'h50, 8'h00);
    @(negedge sys_clk);
    chk("pout_hi", {30'h0, port_out[5:4]}, 32'h00000001);
    chk("oe", {26'h0, port_oe}, 32'h00000030);
    dcc_analog_model_inst.set_levels(8'h28, 8'h14, 8'h0A, 8'h10, 8'h00);
    @(negedge sys_clk);
    chk("pout_hi", {30'h0, port_out[5:4]}, 32'h00000000);
    // unmapped place reads zero
    wr(8'h40, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h40, 32'h00000000);
    // comparator 1 on and high, then a change with the flag clear
    wr(`DCC_OFS_CTRL, 32'h00000000);
    dcc_analog_model_inst.set_levels(8'h28, 8'h14, 8'h0A, 8'h50, 8'h00);
    repeat (6) @(posedge sys_clk);
    rdchk("ctrl", `DCC_OFS_CTRL, 32'h00000040);
    wr(`DCC_OFS_IRQ_REQ2, 32'h00000000);
    rdchk("flag", `DCC_OFS_IRQ_REQ2, 32'h00000000);
    wr(`DCC_OFS_IRQ_EN2, 32'h00000040);
    wr(`DCC_OFS_IRQ_MAIN, 32'h000000C0);
    dcc_analog_model_inst.set_levels(8'h28, 8'h14, 8'h0A, 8'h10, 8'h00);
    repeat (6) @(posedge sys_clk);
    rdchk("flag", `DCC_OFS_IRQ_REQ2, 32'h00000040);
    chk("irq", {31'h0, irq}, 32'h00000001);
    // mismatch still pending: clearing does not hold
    wr(`DCC_OFS_IRQ_REQ2, 32'h00000000);
    rdchk("flag", `DCC_OFS_IRQ_REQ2, 32'h00000040);
    rdchk("ctrl", `DCC_OFS_CTRL, 32'h00000000);
    wr(`DCC_OFS_IRQ_REQ2, 32'h00000000);
    rdchk("flag", `DCC_OFS_IRQ_REQ2, 32'h00000000);
    @(negedge sys_clk);
    chk("irq", {31'h0, irq}, 32'h00000000);
    // software set, then global enable off
    wr(`DCC_OFS_IRQ_REQ2, 32'h00000040);
    @(negedge sys_clk);
    chk("irq", {31'h0, irq}, 32'h00000001);
    wr(`DCC_OFS_IRQ_MAIN, 32'h00000040);
    @(negedge sys_clk);
    chk("irq", {31'h0, irq}, 32'h00000000);
    rdchk("flag", `DCC_OFS_IRQ_REQ2, 32'h00000040);
    // sleep: enabled flag wakes, control unchanged
    sleep <= 1'b1;
    @(negedge sys_clk);
    chk("wake", {31'h0, wake}, 32'h00000001);
    rdchk("ctrl", `DCC_OFS_CTRL, 32'h00000000);
    wr(`DCC_OFS_IRQ_REQ2, 32'h00000000);
    @(negedge sys_clk);
    chk("wake", {31'h0, wake}, 32'h00000000);
    sleep <= 1'b0;
    // second reset in mid-run
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    check_reset_vals();
    give_verdict();
  end
endmodule

`default_nettype wire
